// File: dmx_core.sv
/*
 Execution of the data-move instruction group with its own nibble storage.
 Software issues an instruction by writing its word over APB; it executes
 in that same access edge. Change-detect pins are asynchronous.
*/
// Overview of operation
// RL1: Page-read copies page select into accumulator and memory, sets zero flag.
// RL2: Port-change read copies change flags to accumulator and memory, zero flag.
// RL3: Each change flag is 1 after its pin changed, else 0.
// RL4: Serial-status read copies serial flags to accumulator and memory, zero flag.
// RL5: Working register copied to accumulator and memory in one cycle, zero flag.
// RL6: Memory nibble copied to working register and accumulator, zero flag.
// RL7: Table-low load writes memory nibble into low table pointer.
// RL8: Table-high load writes memory nibble into high table pointer.
// RL9: Lookup address is high pointer times sixteen plus low pointer.
// RL10: Page select loads from memory; low three bits give page base.
// RL11: Zero flag set when moved nibble is zero, cleared otherwise.
// RL12: Table pointer loads leave accumulator, zero and carry flags alone.
`timescale 1ns/10ps
`default_nettype none
module dmx_core (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire dmx_pkg::dmx_apb_req_type apb_req_in,
  output dmx_pkg::dmx_apb_rsp_type apb_rsp_out,
  input wire logic [3:0] change_detect_port_in,
  input wire logic [3:0] serial_status_flags_in,
  output logic [7:0] table_rom_addr_out,
  output logic [6:0] page_base_addr_out
);
  import dmx_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [3:0] accumulator_reg;
  logic zero_flag_reg;
  logic carry_flag_reg;
  logic [3:0] page_select_reg;
  logic [3:0] table_pointer_low_reg;
  logic [3:0] table_pointer_high_reg;
  logic [3:0] port_change_flags_reg;
  logic [3:0] chg_sync1_reg;
  logic [3:0] chg_sync2_reg;
  logic [3:0] chg_prev_reg;
  logic [3:0] serial_sync1_reg;
  logic [3:0] serial_status_flags_reg;
  logic [3:0] mem_reg [DMX_MEM_DEPTH];
  logic [6:0] mem_sel_reg;
  logic [3:0] wsel_sel_reg;
  logic [31:0] prdata_reg;
  dmx_dec_type dec;
  logic [15:0] instr_word;
  logic exec;
  logic wr_acc;
  logic rd_acc;
  logic clr_chg;
  logic [3:0] src_nibble;
  logic [3:0] mem_nibble;
  logic [3:0] chg_event;
  logic slv_err;

  function automatic logic is_zero(input logic [3:0] v);
    return v == 4'h0; // RL11
  endfunction : is_zero

  ////////////////////////////////////////////////////////////////////////
  assign wr_acc = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
  assign rd_acc = apb_req_in.psel && apb_req_in.penable && !apb_req_in.pwrite;
  assign instr_word = apb_req_in.pwdata[15:0];
  assign exec = wr_acc && (apb_req_in.paddr == DMX_ADDR_INSTR);
  assign clr_chg = wr_acc && (apb_req_in.paddr == DMX_ADDR_CHG_CLR);

  dmx_decoder u_dec (
    .instr_in(instr_word),
    .dec_out(dec)
  );

  assign mem_nibble = mem_reg[dec.addr];
  // Any sampled transition counts, rising or falling
  assign chg_event = chg_sync2_reg ^ chg_prev_reg;

  always_comb begin
    src_nibble = mem_nibble;
    if (instr_word[15:7] == DMX_OP_PAGE_READ) begin
      src_nibble = page_select_reg; // RL1
    end else if (instr_word[15:7] == DMX_OP_CHG_READ) begin
      src_nibble = port_change_flags_reg; // RL2
    end else if (instr_word[15:7] == DMX_OP_SER_READ) begin
      src_nibble = serial_status_flags_reg; // RL4
    end else if (dec.kind == DMX_K_TO_ACC_MEM) begin
      src_nibble = mem_reg[{3'h0, dec.wsel}]; // RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chg_sync1_reg <= DMX_NIBBLE_RST;
      chg_sync2_reg <= DMX_NIBBLE_RST;
      chg_prev_reg <= DMX_NIBBLE_RST;
      serial_sync1_reg <= DMX_NIBBLE_RST;
      serial_status_flags_reg <= DMX_NIBBLE_RST;
    end else begin
      chg_sync1_reg <= change_detect_port_in;
      chg_sync2_reg <= chg_sync1_reg;
      chg_prev_reg <= chg_sync2_reg;
      serial_sync1_reg <= serial_status_flags_in;
      serial_status_flags_reg <= serial_sync1_reg;
    end
  end

  // Sticky change flags; a new change wins over a clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_change_flags_reg <= DMX_NIBBLE_RST;
    end else if (clr_chg) begin
      port_change_flags_reg <= (port_change_flags_reg & ~apb_req_in.pwdata[3:0]) | chg_event; // RL3
    end else begin
      port_change_flags_reg <= port_change_flags_reg | chg_event; // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator and flags
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      accumulator_reg <= DMX_NIBBLE_RST;
      zero_flag_reg <= 1'b0;
      carry_flag_reg <= 1'b0;
    end else if (exec) begin
      unique case (dec.kind)
        DMX_K_TO_ACC_MEM: begin
          accumulator_reg <= src_nibble; // RL1
          zero_flag_reg <= is_zero(src_nibble); // RL11
        end
        DMX_K_MEM_TO_WR: begin
          accumulator_reg <= mem_nibble; // RL6
          zero_flag_reg <= is_zero(mem_nibble); // RL11
        end
        // Table loads and others keep flags
        default: accumulator_reg <= accumulator_reg; // RL12
      endcase
    end
  end

  // Data memory; working registers are its lowest sixteen nibbles
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DMX_MEM_DEPTH; i++) begin
        mem_reg[i] <= DMX_NIBBLE_RST;
      end
    end else if (exec && dec.kind == DMX_K_TO_ACC_MEM) begin
      // Instruction writes and window writes never share an access
      mem_reg[dec.addr] <= src_nibble; // RL2
    end else if (exec && dec.kind == DMX_K_MEM_TO_WR) begin
      mem_reg[{3'h0, dec.wsel}] <= mem_nibble; // RL6
    end else if (wr_acc && apb_req_in.paddr == DMX_ADDR_MEM) begin
      mem_reg[apb_req_in.pwdata[14:8]] <= apb_req_in.pwdata[3:0];
    end
  end

  // Page select and table pointers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      page_select_reg <= DMX_NIBBLE_RST;
      table_pointer_low_reg <= DMX_NIBBLE_RST;
      table_pointer_high_reg <= DMX_NIBBLE_RST;
    end else if (exec) begin
      unique case (dec.kind)
        DMX_K_TAB_LOW: table_pointer_low_reg <= mem_nibble; // RL7
        DMX_K_TAB_HIGH: table_pointer_high_reg <= mem_nibble; // RL8
        DMX_K_PAGE_LOAD: page_select_reg <= mem_nibble; // RL10
        default: page_select_reg <= page_select_reg;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      table_rom_addr_out <= 8'h00;
      page_base_addr_out <= 7'h00;
    end else begin
      table_rom_addr_out <= {table_pointer_high_reg, table_pointer_low_reg}; // RL9
      page_base_addr_out <= {page_select_reg[2:0], 4'h0}; // RL10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB read side; selectors latched by writes to the window registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_sel_reg <= 7'h00;
      wsel_sel_reg <= 4'h0;
    end else if (wr_acc && apb_req_in.paddr == DMX_ADDR_MEM) begin
      mem_sel_reg <= apb_req_in.pwdata[14:8];
    end else if (wr_acc && apb_req_in.paddr == DMX_ADDR_WREG) begin
      wsel_sel_reg <= apb_req_in.pwdata[3:0];
    end
  end

  always_comb begin
    prdata_reg = 32'h0000_0000;
    unique case (apb_req_in.paddr)
      DMX_ADDR_STATE: prdata_reg = {24'h0, page_select_reg, 1'b0, carry_flag_reg,
                                    zero_flag_reg, 1'b0} | {28'h0, accumulator_reg} << 8;
      DMX_ADDR_TABLE: prdata_reg = {24'h0, table_pointer_high_reg, table_pointer_low_reg};
      DMX_ADDR_MEM: prdata_reg = {17'h0, mem_sel_reg, 4'h0, mem_reg[mem_sel_reg]};
      DMX_ADDR_WREG: prdata_reg = {28'h0, mem_reg[{3'h0, wsel_sel_reg}]};
      DMX_ADDR_SERIAL: prdata_reg = {28'h0, serial_status_flags_reg};
      DMX_ADDR_CHG_CLR: prdata_reg = {28'h0, port_change_flags_reg};
      default: prdata_reg = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // No wait states: every access ends in its first access cycle
  assign slv_err = apb_req_in.psel && apb_req_in.penable &&
    !(apb_req_in.paddr inside {DMX_ADDR_INSTR, DMX_ADDR_STATE, DMX_ADDR_TABLE,
      DMX_ADDR_MEM, DMX_ADDR_WREG, DMX_ADDR_SERIAL, DMX_ADDR_CHG_CLR});
  // One driver for the whole response struct: prdata, pready, pslverr
  assign apb_rsp_out = {(rd_acc ? prdata_reg : 32'h0000_0000), 1'b1, slv_err};
endmodule : dmx_core
`default_nettype wire

// File: dmx_pkg.sv
/*
 Package for the data-move execution block: opcode patterns, register map,
 reset values and bus structs.
 Assumes 16-bit instruction words, 4-bit data nibbles, APB with 32-bit data.
*/
package dmx_pkg;

  // Opcode patterns (upper bits of a 16-bit word)
  localparam logic [8:0] DMX_OP_PAGE_READ = 9'h0BF;
  localparam logic [8:0] DMX_OP_CHG_READ = 9'h09E;
  localparam logic [8:0] DMX_OP_SER_READ = 9'h0BE;
  localparam logic [3:0] DMX_OP_WR_TO_MEM = 4'h7;
  localparam logic [4:0] DMX_OP_MEM_TO_WR = 5'h0D;
  localparam logic [8:0] DMX_OP_TAB_LOW = 9'h130;
  localparam logic [8:0] DMX_OP_TAB_HIGH = 9'h131;
  localparam logic [6:0] DMX_OP_PAGE_LOAD = 7'h2E;

  // APB register byte offsets
  localparam logic [7:0] DMX_ADDR_INSTR = 8'h00;
  localparam logic [7:0] DMX_ADDR_STATE = 8'h04;
  localparam logic [7:0] DMX_ADDR_TABLE = 8'h08;
  localparam logic [7:0] DMX_ADDR_MEM = 8'h0C;
  localparam logic [7:0] DMX_ADDR_WREG = 8'h10;
  localparam logic [7:0] DMX_ADDR_SERIAL = 8'h14;
  localparam logic [7:0] DMX_ADDR_CHG_CLR = 8'h18;

  // Reset values and sizes
  localparam logic [3:0] DMX_NIBBLE_RST = 4'h0;
  localparam int DMX_MEM_DEPTH = 128;
  localparam int DMX_WREG_DEPTH = 16;
  localparam int DMX_PAGE_SIZE = 16;

  typedef enum logic [2:0] {
    DMX_K_NONE,
    DMX_K_TO_ACC_MEM,
    DMX_K_MEM_TO_WR,
    DMX_K_TAB_LOW,
    DMX_K_TAB_HIGH,
    DMX_K_PAGE_LOAD
  } dmx_kind_type;

  typedef struct packed {
    dmx_kind_type kind;
    logic [3:0] wsel;
    logic [6:0] addr;
  } dmx_dec_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dmx_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dmx_apb_rsp_type;

endpackage : dmx_pkg

// File: dmx_decoder.sv
/*
 Combinational decoder for the data-move instruction group.
 Assumes the word is stable for the cycle that executes it.
*/
`timescale 1ns/10ps
`default_nettype none
module dmx_decoder (
  input wire logic [15:0] instr_in,
  output dmx_pkg::dmx_dec_type dec_out
);
  import dmx_pkg::*;

  always_comb begin
    dec_out.kind = DMX_K_NONE;
    dec_out.wsel = instr_in[10:7];
    dec_out.addr = instr_in[6:0];
    if (instr_in[15:7] == DMX_OP_PAGE_READ) begin
      dec_out.kind = DMX_K_TO_ACC_MEM; // RL1
    end else if (instr_in[15:7] == DMX_OP_CHG_READ) begin
      dec_out.kind = DMX_K_TO_ACC_MEM; // RL2
    end else if (instr_in[15:7] == DMX_OP_SER_READ) begin
      dec_out.kind = DMX_K_TO_ACC_MEM; // RL4
    end else if (instr_in[15:7] == DMX_OP_TAB_LOW) begin
      dec_out.kind = DMX_K_TAB_LOW; // RL7
    end else if (instr_in[15:7] == DMX_OP_TAB_HIGH) begin
      dec_out.kind = DMX_K_TAB_HIGH; // RL8
    end else if (instr_in[15:9] == DMX_OP_PAGE_LOAD) begin
      dec_out.kind = DMX_K_PAGE_LOAD; // RL10
    end else if (instr_in[15:12] == DMX_OP_WR_TO_MEM) begin
      dec_out.kind = DMX_K_TO_ACC_MEM; // RL5
      dec_out.wsel = instr_in[10:7];
    end else if (instr_in[15:11] == DMX_OP_MEM_TO_WR) begin
      dec_out.kind = DMX_K_MEM_TO_WR; // RL6
    end
  end
endmodule : dmx_decoder
`default_nettype wire

// File: dmx_core_asserts.sv
/*
 Port checker for dmx_core.
 Assumes APB levels from the bench and the register map of dmx_pkg.
*/
`timescale 1ns/10ps
`default_nettype none
module dmx_core_asserts (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire dmx_pkg::dmx_apb_req_type apb_req_in,
  input wire dmx_pkg::dmx_apb_rsp_type apb_rsp_out,
  input wire logic [3:0] change_detect_port_in,
  input wire logic [3:0] serial_status_flags_in,
  input wire logic [7:0] table_rom_addr_out,
  input wire logic [6:0] page_base_addr_out
);
  import dmx_pkg::*;
  logic acc_ph;
  logic ex_ph;
  logic mapped;
  logic [1:0] up_reg;
  assign acc_ph = apb_req_in.psel && apb_req_in.penable;
  assign ex_ph = acc_ph && apb_req_in.pwrite && apb_req_in.paddr == DMX_ADDR_INSTR;
  assign mapped = apb_req_in.paddr <= DMX_ADDR_CHG_CLR && apb_req_in.paddr[1:0] == 2'h0;
  // Synchroniser needs a few edges after reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  ready_high_a: assert property (apb_rsp_out.pready) else $error("pready low");
  err_decode_a: assert property (acc_ph |-> apb_rsp_out.pslverr == !mapped)
    else $error("pslverr wrong");
  err_idle_a: assert property (!acc_ph |-> !apb_rsp_out.pslverr) else $error("pslverr idle");
  rdata_idle_a: assert property (!(apb_req_in.psel && !apb_req_in.pwrite)
    |-> apb_rsp_out.prdata == 32'h0) else $error("prdata idle");
  table_hold_a: assert property ($changed(table_rom_addr_out)
    |-> $past(ex_ph) || $past(ex_ph, 2)) else $error("table moved");
  page_hold_a: assert property ($changed(page_base_addr_out)
    |-> $past(ex_ph) || $past(ex_ph, 2)) else $error("page moved");
  page_low_a: assert property (page_base_addr_out[3:0] == 4'h0) else $error("page low");
  serial_view_a: assert property (acc_ph && !apb_req_in.pwrite && up_reg == 2'h3
    && apb_req_in.paddr == DMX_ADDR_SERIAL && $stable(serial_status_flags_in)
    && $past(serial_status_flags_in, 2) == serial_status_flags_in
    |-> apb_rsp_out.prdata == {28'h0, serial_status_flags_in}) else $error("serial view");
endmodule : dmx_core_asserts
bind dmx_core dmx_core_asserts chk_u (.clk_in(clk_in), .nrst_in(nrst_in),
  .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out),
  .change_detect_port_in(change_detect_port_in),
  .serial_status_flags_in(serial_status_flags_in),
  .table_rom_addr_out(table_rom_addr_out), .page_base_addr_out(page_base_addr_out));
`default_nettype wire

// File: testbench.sv
/*
 Self-checking bench for dmx_core over APB.
 Assumes pready answers in the access phase and instructions run on write.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dmx_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  dmx_apb_req_type req = '0;
  dmx_apb_rsp_type rsp;
  logic [3:0] chg = 4'h0;
  logic [3:0] ser = 4'h0;
  logic [7:0] tab;
  logic [6:0] pbase;
  int errors = 0;
  int n_compared = 0;
  always #4 clk_in = ~clk_in;
  dmx_core dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .apb_req_in(req),
    .apb_rsp_out(rsp), .change_detect_port_in(chg), .serial_status_flags_in(ser),
    .table_rom_addr_out(tab), .page_base_addr_out(pbase));
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Edge first, so a release never meets the next setup in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_in);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      errors++;
      $display("[ERR] %0t bus timeout", $time);
      complete_run();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    bus(1'b1, a, d, r, e);
    check({31'h0, e}, 32'h0);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    bus(1'b0, a, 32'h0, r, e);
    check({e, r[30:0]}, x);
  endtask : rc
  task automatic mw(input logic [6:0] a, input logic [3:0] d);
    wr(DMX_ADDR_MEM, {17'h0, a, 4'h0, d});
  endtask : mw
  task automatic ex(input logic [15:0] w);
    wr(DMX_ADDR_INSTR, {16'h0, w});
  endtask : ex
  task automatic wchk(input logic [3:0] s, input logic [3:0] x);
    wr(DMX_ADDR_WREG, {28'h0, s});
    rc(DMX_ADDR_WREG, {28'h0, x});
  endtask : wchk
  function automatic logic [31:0] st(input logic [3:0] a, input logic [3:0] p, input logic z);
    return {20'h0, a, p, 2'h0, z, 1'b0};
  endfunction : st
  ////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] v;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    rc(DMX_ADDR_STATE, 32'h0);
    rc(DMX_ADDR_TABLE, 32'h0);
    mw(7'h25, 4'hA);
    ex({DMX_OP_MEM_TO_WR, 4'h3, 7'h25});
    rc(DMX_ADDR_STATE, st(4'hA, 4'h0, 1'b0));
    wchk(4'h3, 4'hA);
    mw(7'h41, 4'h0);
    ex({DMX_OP_MEM_TO_WR, 4'h3, 7'h41});
    rc(DMX_ADDR_STATE, st(4'h0, 4'h0, 1'b1));
    mw(7'h0F, 4'h5);
    // Index bits all ones: same register whichever field slice is used
    ex({DMX_OP_WR_TO_MEM, 5'h1F, 7'h40});
    rc(DMX_ADDR_STATE, st(4'h5, 4'h0, 1'b0));
    ex({DMX_OP_MEM_TO_WR, 4'h2, 7'h40});
    wchk(4'h2, 4'h5);
    $display("moves done");
    mw(7'h30, 4'hD);
    ex({DMX_OP_PAGE_LOAD, 2'h0, 7'h30});
    rc(DMX_ADDR_STATE, st(4'h5, 4'hD, 1'b0));
    check({25'h0, pbase}, 32'h50);
    ex({DMX_OP_PAGE_READ, 7'h31});
    rc(DMX_ADDR_STATE, st(4'hD, 4'hD, 1'b0));
    ex({DMX_OP_MEM_TO_WR, 4'h4, 7'h31});
    wchk(4'h4, 4'hD);
    mw(7'h50, 4'h6);
    mw(7'h51, 4'h9);
    rc(DMX_ADDR_MEM, {17'h0, 7'h51, 4'h0, 4'h9});
    ex({DMX_OP_TAB_LOW, 7'h50});
    ex({DMX_OP_TAB_HIGH, 7'h51});
    rc(DMX_ADDR_TABLE, 32'h96);
    rc(DMX_ADDR_STATE, st(4'hD, 4'hD, 1'b0));
    check({24'h0, tab}, 32'h96);
    // Zero nibble into the pointer: the zero flag must stay clear
    ex({DMX_OP_TAB_LOW, 7'h41});
    rc(DMX_ADDR_STATE, st(4'hD, 4'hD, 1'b0));
    rc(DMX_ADDR_TABLE, 32'h90);
    check({24'h0, tab}, 32'h90);
    ex(16'h0000);
    rc(DMX_ADDR_STATE, st(4'hD, 4'hD, 1'b0));
    $display("page and table done");
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 4'h0 : 4'hB;
      ser <= v;
      repeat (4) @(posedge clk_in);
      rc(DMX_ADDR_SERIAL, {28'h0, v});
      ex({DMX_OP_SER_READ, 7'h60});
      rc(DMX_ADDR_STATE, st(v, 4'hD, v == 4'h0));
    end
    ex({DMX_OP_MEM_TO_WR, 4'h6, 7'h60});
    wchk(4'h6, 4'hB);
    rc(DMX_ADDR_CHG_CLR, 32'h0);
    chg <= 4'h5;
    repeat (4) @(posedge clk_in);
    rc(DMX_ADDR_CHG_CLR, 32'h5);
    ex({DMX_OP_CHG_READ, 7'h61});
    rc(DMX_ADDR_STATE, st(4'h5, 4'hD, 1'b0));
    wr(DMX_ADDR_CHG_CLR, 32'h5);
    rc(DMX_ADDR_CHG_CLR, 32'h0);
    ex({DMX_OP_CHG_READ, 7'h61});
    rc(DMX_ADDR_STATE, st(4'h0, 4'hD, 1'b1));
    ex({DMX_OP_MEM_TO_WR, 4'h5, 7'h61});
    wchk(4'h5, 4'h0);
    chg <= 4'h0;
    repeat (4) @(posedge clk_in);
    rc(DMX_ADDR_CHG_CLR, 32'h5);
    rc(8'h1C, 32'h80000000);
    rc(8'h40, 32'h80000000);
    $display("status and decode done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
